//--- hdl/cmcr_regs.sv
// cmcr_regs: four 8-bit mode control registers reached by 16-bit serial frames
// assumes a deserialiser hands one frame per frame_valid pulse and takes the answer frame
// Operation
// - switching bit 0: spread deviation, 0 is 16 percent, 1 is 8 percent
// - switching bit 1: spread modulation rate, 0 is 12 kHz, 1 is 18 kHz
// - switching bit 2 enables spread spectrum; reset value 0
// - switching bit 3 set disables ground short protection; reset 0 enabled
// - switching bit 4 set disables input voltage feedback; reset 0 enabled
// - switching bit 5 set applies forced continuous conduction during soft start
// - switching bit 6 set enables discontinuous mode, fourth switch held off
// - control bit 0 set puts the device into idle mode
// - writing 1 to control bit 1 issues a software reset; reads 0
// - writing 1 to control bit 2 issues latch clear; reads 0
// - control bit 3 selects automatic calibration result and permits calibration start
// - control bits 5:4 choose slope compensation strength; reset nominal
// - control bit 6 boosts amplifier gain below 80 percent target current
// - control bit 7 reduces amplifier saturation current to 10 microamps
// - float setup bits 3:0 give jump ratio; 0000 means 16; reset 1000
// - float setup bit 4 reads done; cleared by start write, set on success
// - writing 1 to float setup bit 5 starts the float switch routine
// - float setup bit 6 halves discharge current limit, else two thirds
// - float setup bit 7 cuts amplifier current to 20 percent during routine
// - float delay register holds 8-bit delay code, reset 10000000
// - unknown address writes ignored; unknown reads return the diagnosis frame
// - frame bit 15 is write, bits 14:8 address, bits 7:0 data
`timescale 1ns/1ps
`default_nettype none

module cmcr_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        frame_valid,
	input  wire logic [15:0] frame_in,
	input  wire logic [15:0] diag_frame,
	input  wire logic        float_switch_ok,
	input  wire logic        float_switch_fail,
	output logic             resp_valid,
	output logic [15:0]      resp_frame,
	output logic             spread_deviation_sel,
	output logic             spread_rate_sel,
	output logic             spread_enable,
	output logic             ground_short_prot_disable,
	output logic             input_feedback_disable,
	output logic             forced_continuous_early,
	output logic             discontinuous_enable,
	output logic             idle_mode,
	output logic             soft_reset_cmd,
	output logic             latch_clear_cmd,
	output logic             auto_calib_source,
	output logic [1:0]       slope_comp_sel,
	output logic             amp_gain_boost,
	output logic             amp_sat_reduce,
	output logic [3:0]       jump_ratio,
	output logic             float_switch_done,
	output logic             float_switch_start,
	output logic             float_switch_busy,
	output logic             discharge_limit_half,
	output logic             amp_current_reduce_float,
	output logic [7:0]       float_switch_delay_code
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]  sw_mode;
		logic [7:0]  dev_ctrl;
		logic [7:0]  fs_setup;
		logic [7:0]  fs_delay;
		logic        soft_rst;
		logic        latch_clr;
		logic        fs_start;
		logic        resp_vld;
		logic [15:0] resp;
	} cmcr_state_t;

	cmcr_state_t st_r;
	cmcr_state_t st_nxt;

	logic             wr;
	logic [6:0]       addr;
	logic [7:0]       wdata;

	assign wr    = frame_in[cmcr_pkg::FRAME_WR_BIT];
	assign addr  = frame_in[cmcr_pkg::ADDR_MSB:cmcr_pkg::ADDR_LSB];
	assign wdata = frame_in[cmcr_pkg::DATA_W-1:0];

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt           = st_r;
		st_nxt.soft_rst  = 1'b0;
		st_nxt.latch_clr = 1'b0;
		st_nxt.fs_start  = 1'b0;
		st_nxt.resp_vld  = 1'b0;
		// routine ends on either outcome; busy flag follows it
		if (float_switch_ok || float_switch_fail) begin
			st_nxt.fs_setup[cmcr_pkg::FS_START] = 1'b0;
		end
		if (frame_valid) begin
			st_nxt.resp_vld = 1'b1;
			st_nxt.resp     = diag_frame;
			if (wr) begin
				case (addr)
					cmcr_pkg::ADDR_SWITCHING_MODE: begin
						st_nxt.sw_mode = wdata & cmcr_pkg::SM_USED_MASK;
					end
					cmcr_pkg::ADDR_DEVICE_CONTROL: begin
						st_nxt.dev_ctrl  = wdata & cmcr_pkg::DC_STORED_MASK;
						st_nxt.soft_rst  = wdata[cmcr_pkg::DC_SOFT_RESET];
						st_nxt.latch_clr = wdata[cmcr_pkg::DC_LATCH_CLEAR];
					end
					cmcr_pkg::ADDR_FLOAT_SETUP: begin
						// done and start bits are not stored from the frame
						st_nxt.fs_setup = (wdata & cmcr_pkg::FS_STORED_MASK)
							| (st_nxt.fs_setup & ~cmcr_pkg::FS_STORED_MASK);
						if (wdata[cmcr_pkg::FS_START]) begin
							st_nxt.fs_start = 1'b1;
							st_nxt.fs_setup[cmcr_pkg::FS_START] = 1'b1;
							st_nxt.fs_setup[cmcr_pkg::FS_DONE]  = 1'b0;
						end
					end
					cmcr_pkg::ADDR_FLOAT_DELAY: begin
						st_nxt.fs_delay = wdata;
					end
					default: begin
						st_nxt.resp = diag_frame;
					end
				endcase
			end else begin
				case (addr)
					cmcr_pkg::ADDR_SWITCHING_MODE: st_nxt.resp = {1'b0, addr, st_r.sw_mode};
					cmcr_pkg::ADDR_DEVICE_CONTROL: st_nxt.resp = {1'b0, addr, st_r.dev_ctrl};
					cmcr_pkg::ADDR_FLOAT_SETUP:    st_nxt.resp = {1'b0, addr, st_r.fs_setup};
					cmcr_pkg::ADDR_FLOAT_DELAY:    st_nxt.resp = {1'b0, addr, st_r.fs_delay};
					default:                       st_nxt.resp = diag_frame;
				endcase
			end
		end
		// success set wins over a clear by start in the same cycle
		if (float_switch_ok) begin
			st_nxt.fs_setup[cmcr_pkg::FS_DONE] = 1'b1;
		end
		// software reset restores defaults one cycle after the command pulse
		if (st_r.soft_rst) begin
			st_nxt.sw_mode  = cmcr_pkg::SM_RESET;
			st_nxt.dev_ctrl = cmcr_pkg::DC_RESET;
			st_nxt.fs_setup = cmcr_pkg::FS_RESET;
			st_nxt.fs_delay = cmcr_pkg::FD_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.sw_mode   <= cmcr_pkg::SM_RESET;
			st_r.dev_ctrl  <= cmcr_pkg::DC_RESET;
			st_r.fs_setup  <= cmcr_pkg::FS_RESET;
			st_r.fs_delay  <= cmcr_pkg::FD_RESET;
			st_r.soft_rst  <= 1'b0;
			st_r.latch_clr <= 1'b0;
			st_r.fs_start  <= 1'b0;
			st_r.resp_vld  <= 1'b0;
			st_r.resp      <= 16'h0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign resp_valid                = st_r.resp_vld;
	assign resp_frame                = st_r.resp;
	assign spread_deviation_sel      = st_r.sw_mode[cmcr_pkg::SM_DEVIATION];
	assign spread_rate_sel           = st_r.sw_mode[cmcr_pkg::SM_RATE];
	assign spread_enable             = st_r.sw_mode[cmcr_pkg::SM_SPREAD_EN];
	assign ground_short_prot_disable = st_r.sw_mode[cmcr_pkg::SM_GND_PROT];
	assign input_feedback_disable    = st_r.sw_mode[cmcr_pkg::SM_INPUT_FB];
	assign forced_continuous_early   = st_r.sw_mode[cmcr_pkg::SM_CCM_EARLY];
	assign discontinuous_enable      = st_r.sw_mode[cmcr_pkg::SM_DISCONTINUOUS_ENABLE];
	assign idle_mode                 = st_r.dev_ctrl[cmcr_pkg::DC_IDLE];
	assign soft_reset_cmd            = st_r.soft_rst;
	assign latch_clear_cmd           = st_r.latch_clr;
	assign auto_calib_source         = st_r.dev_ctrl[cmcr_pkg::DC_CALIB_SRC];
	assign slope_comp_sel            = st_r.dev_ctrl[cmcr_pkg::DC_SLOPE_MSB:cmcr_pkg::DC_SLOPE_LSB];
	assign amp_gain_boost            = st_r.dev_ctrl[cmcr_pkg::DC_GAIN_BOOST];
	assign amp_sat_reduce            = st_r.dev_ctrl[cmcr_pkg::DC_SAT_REDUCE];
	assign jump_ratio                = st_r.fs_setup[cmcr_pkg::FS_RATIO_MSB:cmcr_pkg::FS_RATIO_LSB];
	assign float_switch_done         = st_r.fs_setup[cmcr_pkg::FS_DONE];
	assign float_switch_start        = st_r.fs_start;
	assign float_switch_busy         = st_r.fs_setup[cmcr_pkg::FS_START];
	assign discharge_limit_half      = st_r.fs_setup[cmcr_pkg::FS_LIMIT_HALF];
	assign amp_current_reduce_float  = st_r.fs_setup[cmcr_pkg::FS_AMP_REDUCE];
	assign float_switch_delay_code   = st_r.fs_delay;

endmodule // cmcr_regs

`default_nettype wire

//--- hdl/cmcr_pkg.sv
// cmcr_pkg: offsets, field positions, reset values of the converter mode control registers
// assumes frames of 16 bits arrive already deserialised from the serial port
package cmcr_pkg;

	// ****************************************
	// frame layout
	// ****************************************
	localparam int FRAME_W      = 16;
	localparam int FRAME_WR_BIT = 15;
	localparam int ADDR_MSB     = 14;
	localparam int ADDR_LSB     = 8;
	localparam int ADDR_W       = 7;
	localparam int DATA_W       = 8;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [6:0] ADDR_SWITCHING_MODE = 7'h05;
	localparam logic [6:0] ADDR_DEVICE_CONTROL = 7'h06;
	localparam logic [6:0] ADDR_FLOAT_SETUP    = 7'h09;
	localparam logic [6:0] ADDR_FLOAT_DELAY    = 7'h0a;

	// ****************************************
	// switching_mode_config fields
	// ****************************************
	localparam int SM_DEVIATION   = 0;
	localparam int SM_RATE        = 1;
	localparam int SM_SPREAD_EN   = 2;
	localparam int SM_GND_PROT    = 3;
	localparam int SM_INPUT_FB    = 4;
	localparam int SM_CCM_EARLY   = 5;
	localparam int SM_DISCONTINUOUS_ENABLE      = 6;
	localparam logic [7:0] SM_USED_MASK = 8'h7f;
	localparam logic [7:0] SM_RESET     = 8'h00;

	// ****************************************
	// device_control fields
	// ****************************************
	localparam int DC_IDLE        = 0;
	localparam int DC_SOFT_RESET  = 1;
	localparam int DC_LATCH_CLEAR = 2;
	localparam int DC_CALIB_SRC   = 3;
	localparam int DC_SLOPE_LSB   = 4;
	localparam int DC_SLOPE_MSB   = 5;
	localparam int DC_GAIN_BOOST  = 6;
	localparam int DC_SAT_REDUCE  = 7;
	localparam logic [7:0] DC_STORED_MASK = 8'hf9;
	localparam logic [7:0] DC_RESET       = 8'h00;

	// ****************************************
	// float_switch_setup_one fields
	// ****************************************
	localparam int FS_RATIO_LSB   = 0;
	localparam int FS_RATIO_MSB   = 3;
	localparam int FS_DONE        = 4;
	localparam int FS_START       = 5;
	localparam int FS_LIMIT_HALF  = 6;
	localparam int FS_AMP_REDUCE  = 7;
	localparam logic [7:0] FS_STORED_MASK = 8'hcf;
	localparam logic [7:0] FS_RESET       = 8'h08;

	// ****************************************
	// float_switch_delay
	// ****************************************
	localparam logic [7:0] FD_RESET = 8'h80;

endpackage

//--- sim/cmcr_regs_sva.sv
// cmcr_regs_sva: answer timing and field effects of the register port
// assumes it is bound to cmcr_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cmcr_regs_sva (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        frame_valid,
	input wire logic [15:0] frame_in,
	input wire logic [15:0] diag_frame,
	input wire logic        float_switch_ok,
	input wire logic        resp_valid,
	input wire logic [15:0] resp_frame,
	input wire logic        soft_reset_cmd,
	input wire logic        latch_clear_cmd,
	input wire logic        spread_enable,
	input wire logic [3:0]  jump_ratio,
	input wire logic        float_switch_done,
	input wire logic        float_switch_start,
	input wire logic        float_switch_busy,
	input wire logic [7:0]  float_switch_delay_code
);
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a frame on the soft reset edge is lost, so those edges are left out
	wire logic       wr = frame_valid && frame_in[15] && !soft_reset_cmd;
	wire logic [6:0] ad = frame_in[14:8];
	wire logic       mp = (ad == 7'h05) || (ad == 7'h06) || (ad == 7'h09) || (ad == 7'h0a);
	chk_answer_pulse: assert property (##1 resp_valid == $past(frame_valid))
		else $error("answer pulse does not follow frame");
	chk_write_diag: assert property (wr |=> resp_frame == $past(diag_frame))
		else $error("write answer is not the diagnosis frame");
	chk_read_echo: assert property (frame_valid && !frame_in[15] && mp |=> resp_frame[15:8] == {1'b0, $past(ad)})
		else $error("read answer address wrong");
	chk_unmapped_read: assert property (frame_valid && !frame_in[15] && !mp |=> resp_frame == $past(diag_frame))
		else $error("unmapped read answer wrong");
	chk_soft_reset: assert property (wr && ad == 7'h06 && frame_in[1] |=> soft_reset_cmd ##1
		(jump_ratio == 4'h8 && float_switch_delay_code == 8'h80 && !spread_enable && !float_switch_busy))
		else $error("soft reset missing or defaults not restored");
	chk_latch_clear: assert property (wr && ad == 7'h06 |=> latch_clear_cmd == $past(frame_in[2]))
		else $error("latch clear pulse wrong");
	chk_start_clear: assert property (wr && ad == 7'h09 && frame_in[5] && !float_switch_ok
		|=> float_switch_start && float_switch_busy && !float_switch_done)
		else $error("start write did not start or clear done");
	// a start write on the success edge restarts the routine, so busy may stay up there
	chk_done_set: assert property (float_switch_ok && float_switch_busy && !soft_reset_cmd
		&& !(wr && ad == 7'h09 && frame_in[5])
		|=> float_switch_done && !float_switch_busy)
		else $error("done not set on success");
	chk_delay_store: assert property (wr && ad == 7'h0a |=> float_switch_delay_code == $past(frame_in[7:0]))
		else $error("delay code not stored");
	chk_unmapped_write: assert property (wr && !mp |=> $stable({jump_ratio, float_switch_delay_code, spread_enable}))
		else $error("unmapped write changed a register");
endmodule // cmcr_regs_sva
bind cmcr_regs cmcr_regs_sva cmcr_regs_sva_i (.*);
`default_nettype wire

//--- sim/cmcr_host.sv
// cmcr_host: host model handing whole frames to the register port
// assumes frames are already deserialised; one frame, one answer
`timescale 1ns/1ps
`default_nettype none
module cmcr_host #(
	parameter logic [15:0] DIAG = 16'h5a3c
) (
	input  wire logic        clk,
	input  wire logic        resp_valid,
	input  wire logic [15:0] resp_frame,
	output logic             frame_valid,
	output logic [15:0]      frame_in,
	output logic [15:0]      diag_frame
);
	assign diag_frame = DIAG;
	initial begin
		frame_valid = 1'b0;
		frame_in = 16'h0000;
	end
	// whole frame, write flag on top, answer one cycle later
	task automatic xfer(input logic [15:0] f, output logic [15:0] r, output logic ok);
		@(posedge clk);
		#1 frame_valid = 1'b1;
		frame_in = f;
		@(posedge clk);
		#1 frame_valid = 1'b0;
		// inverted so a stale frame is never mistaken for a held one
		frame_in = ~f;
		ok = (resp_valid === 1'b1);
		r = resp_frame;
	endtask
endmodule // cmcr_host
`default_nettype wire

//--- sim/cmcr_regs_bench.sv
// cmcr_regs_bench: write and read sequences against the mode control registers
// assumes cmcr_host supplies frames; routine results are pulsed here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module cmcr_regs_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ok_p = 1'b0;
	logic        fail_p = 1'b0;
	logic        fv, rv, st;
	logic [15:0] fi, dg, rf;
	logic [6:0]  sm;
	logic [7:0]  dc, fs, dly;
	int          num_errors = 0;
	int          n_compared = 0;
	always #5 clk = ~clk;
	cmcr_host cmcr_host_i (.clk(clk), .resp_valid(rv), .resp_frame(rf), .frame_valid(fv), .frame_in(fi), .diag_frame(dg));
	cmcr_regs cmcr_regs_i (.clk(clk), .rst_n(rst_n), .frame_valid(fv), .frame_in(fi), .diag_frame(dg),
		.float_switch_ok(ok_p), .float_switch_fail(fail_p), .resp_valid(rv), .resp_frame(rf),
		.spread_deviation_sel(sm[0]), .spread_rate_sel(sm[1]), .spread_enable(sm[2]), .ground_short_prot_disable(sm[3]),
		.input_feedback_disable(sm[4]), .forced_continuous_early(sm[5]), .discontinuous_enable(sm[6]),
		.idle_mode(dc[0]), .soft_reset_cmd(dc[1]), .latch_clear_cmd(dc[2]), .auto_calib_source(dc[3]),
		.slope_comp_sel(dc[5:4]), .amp_gain_boost(dc[6]), .amp_sat_reduce(dc[7]), .jump_ratio(fs[3:0]),
		.float_switch_done(fs[4]), .float_switch_start(st), .float_switch_busy(fs[5]), .discharge_limit_half(fs[6]),
		.amp_current_reduce_float(fs[7]), .float_switch_delay_code(dly));
	// ****************************************
	// tasks
	// ****************************************
	task end_of_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tx(input logic [15:0] f, input logic [15:0] e);
		logic [15:0] r;
		logic        ok;
		cmcr_host_i.xfer(f, r, ok);
		`CHK("answer", e, r)
		if (!ok) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		tx({1'b1, a, d}, dg);
	endtask
	task automatic pulse(input logic good);
		@(posedge clk);
		#1 {ok_p, fail_p} = {good, !good};
		@(posedge clk);
		#1 {ok_p, fail_p} = 2'b00;
	endtask
	task automatic defaults;
		tx(16'h0500, 16'h0500);
		tx(16'h0600, 16'h0600);
		tx(16'h0900, 16'h0908);
		tx(16'h0a00, 16'h0a80);
		`CHK("outputs", 31'h00000880, {sm, dc, fs, dly})
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		defaults();
		wr(7'h05, 8'hff);
		`CHK("switching", 7'h7f, sm)
		tx(16'h0500, 16'h057f);
		wr(7'h05, 8'h15);
		`CHK("switching", 7'h15, sm)
		wr(7'h06, 8'hfd);
		`CHK("control", 8'hfd, dc)
		tx(16'h0600, 16'h06f9);
		for (int k = 0; k < 4; k++) begin
			wr(7'h06, {2'b00, 2'(k), 4'h0});
			`CHK("slope", 2'(k), dc[5:4])
		end
		wr(7'h09, 8'hc0);
		`CHK("float", 8'hc0, fs)
		wr(7'h09, 8'he3);
		`CHK("start", 9'h1e3, {st, fs})
		pulse(1'b1);
		`CHK("float", 8'hd3, fs)
		tx(16'h0900, 16'h09d3);
		wr(7'h09, 8'h2f);
		`CHK("float", 8'h2f, fs)
		pulse(1'b0);
		`CHK("float", 8'h0f, fs)
		wr(7'h0a, 8'h00);
		tx(16'h0a00, 16'h0a00);
		wr(7'h0a, 8'hff);
		tx(16'h0a00, 16'h0aff);
		wr(7'h0b, 8'h55);
		tx(16'h0b00, dg);
		`CHK("delay", 8'hff, dly)
		wr(7'h06, 8'h02);
		`CHK("soft reset", 1'b1, dc[1])
		defaults();
		end_of_test();
	end
endmodule // cmcr_regs_bench
`default_nettype wire
